// File: hw/bbx_consts.vh
/*
  constants for the backplane bus board interface (bbx): parity lanes, lane masks,
  width codes, status codes, clock divider and fifo sizing.
  assumes it is included once per design file by its bare name.
*/
// Function
// - address then data share 32 lines
// - data valid only while data strobe low
// - even parity per byte, four bits
// - parity error asserts fault line to master
// - interrupt levels ranked one highest, three lowest
// - each level has enable in/out chain
// - master clock four times bus clock
// - bus clock derived from master clock
// - controlling processor drives normal/system line
// - stop line halts controlling processor
// - five-bit status, 01101 first fetch, 01100 later
// - width lines select byte, word, double word
// - multiprocessor request with acknowledge daisy chain
// - acknowledge passes from in to out
// - dma request, release at instruction end; this board releases at the next idle tick, after the access in flight
// - master request, holder releases at instruction end; this board releases at the next idle tick, after the access in flight
// - available signal hands bus between masters
// - wait line extends access until answered
// - power fail warning triggers state save
// - control lines active low, data positive
// - dma burst then processor takes bus back
`ifndef BBX_CONSTS_VH
`define BBX_CONSTS_VH
`define BBX_DATA_W 32
`define BBX_LANES 4
`define BBX_FIFO_DEPTH 4
`define BBX_CLK_DIV 4
`define BBX_DIV_W 2
`define BBX_DIV_HALF 2'h1
`define BBX_DIV_LAST 2'h3
`define BBX_WID_BYTE 2'h3
`define BBX_WID_WORD 2'h1
`define BBX_WID_DWORD 2'h2
`define BBX_WID_RSVD 2'h0
`define BBX_ST_PROG_FIRST 5'h0d
`define BBX_ST_PROG_NEXT 5'h0c
`define BBX_ST_DATA 5'h08
`define BBX_ST_IDLE 5'h00
`define BBX_LANE_MASK_BYTE 4'h1
`define BBX_LANE_MASK_WORD 4'h3
`define BBX_LANE_MASK_DWORD 4'hf
`endif

// File: hw/bbx_parity_lane.v
/*
  one byte lane of the even parity generator and checker.
  assumes the caller masks lanes that the current access width leaves unused.
*/
`timescale 1ns/1ps
`default_nettype none
module bbx_parity_lane (
  input wire [7:0] byte_in,
  input wire par_in,
  input wire used_in,
  output wire par_out,
  output wire bad_out
);
  // even parity: the bit makes the count of ones in nine bits even
  assign par_out = ^byte_in;
  assign bad_out = used_in & (par_out ^ par_in);
endmodule // bbx_parity_lane
`default_nettype wire

// File: hw/bbx_fifo.v
/*
  small synchronous fifo with valid/ready on both sides.
  assumes a single clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bbx_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_in,
  input wire rst_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output reg [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  reg head_valid_r;
  wire push;
  wire pop_mem;
  wire load_head;
  // head register gives a registered read port; mem holds the rest
  assign load_head = (cnt_r != {(AW+1){1'b0}}) & (~head_valid_r | out_ready_in);
  assign pop_mem = load_head;
  // the head register counts toward the depth, so at most DEPTH words are held
  assign in_ready_out = ((cnt_r + {{AW{1'b0}}, head_valid_r}) != DEPTH[AW:0]);
  assign push = in_valid_in & in_ready_out;
  assign out_valid_out = head_valid_r;
  // storage and pointers
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      head_valid_r <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_r[wr_r] <= in_data_in;
        wr_r <= wr_r + 1'b1;
      end
      if (pop_mem) begin
        out_data_out <= mem_r[rd_r];
        rd_r <= rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
      if (load_head) begin
        head_valid_r <= 1'b1;
      end else if (out_ready_in) begin
        head_valid_r <= 1'b0;
      end
    end
  end
endmodule // bbx_fifo
`default_nettype wire

// File: hw/bbx_board.v
/*
  board-side bus interface of a processor board on a 32-bit multiplexed
  backplane: bus clock divider, address/data strobes, parity, status,
  width select, interrupt and arbitration daisy chains, wait, stop, power fail.
  assumes all inputs synchronous to clk_in (the master clock); bus pins are
  split into input, output and output enable; a testbench resolves the wires.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bbx_consts.vh"
module bbx_board #(
  parameter DW = 32,
  parameter FIFO_DEPTH = 4
) (
  input wire clk_in,
  input wire rst_in,
  // user side: one access request
  input wire req_valid_in,
  output wire req_ready_out,
  input wire req_write_in,
  input wire req_prog_in,
  input wire req_first_in,
  input wire [1:0] req_width_in,
  input wire [DW-1:0] req_addr_in,
  input wire [DW-1:0] req_wdata_in,
  input wire sys_mode_in,
  input wire [2:0] irq_raise_in,
  input wire mp_sync_want_in,
  input wire other_master_want_in,
  output wire rd_valid_out,
  input wire rd_ready_in,
  output wire [DW-1:0] rd_data_out,
  output reg rd_parity_bad_out,
  output reg save_state_out,
  output reg halted_out,
  output reg bus_owned_out,
  output reg [2:0] irq_taken_out,
  output reg mp_sync_granted_out,
  // backplane pins, control lines active low
  output reg bclk_out,
  input wire [DW-1:0] ad_in,
  output reg [DW-1:0] ad_out,
  output reg ad_oe_out,
  input wire [3:0] par_in,
  output reg [3:0] par_out,
  output reg par_oe_out,
  output reg addr_strobe_n_out,
  output reg data_strobe_n_out,
  output reg strobe_oe_out,
  output reg [4:0] transaction_type_code_out,
  output reg byte_sel_out,
  output reg width_sel_b_out,
  output reg normal_mode_out,
  output reg parity_fault_line_oe_out,
  input wire wait_n_in,
  input wire stop_n_in,
  input wire power_fail_warning_n_in,
  output wire [2:0] irq_level_oe_out,
  input wire lvl1_enable_in,
  input wire lvl2_enable_in,
  input wire lvl3_enable_in,
  output wire lvl1_enable_out,
  output wire lvl2_enable_out,
  output wire lvl3_enable_out,
  output reg multiproc_sync_request_oe_out,
  input wire multiproc_ack_in,
  output wire multiproc_ack_out,
  input wire dma_bus_request_n_in,
  input wire dma_grant_in,
  output wire dma_grant_out,
  output reg master_bus_request_oe_out,
  input wire master_grant_in,
  output wire master_grant_out,
  input wire master_available_n_in,
  output reg master_available_oe_out
);
  localparam S_IDLE = 6'h01;
  localparam S_ADDR = 6'h02;
  localparam S_ALAT = 6'h04;
  localparam S_DATA = 6'h08;
  localparam S_DEND = 6'h10;
  localparam S_OFF = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [`BBX_DIV_W-1:0] div_r;
  reg [DW-1:0] wdata_r;
  reg write_r;
  reg [1:0] width_r;
  reg rd_push_r;
  reg [DW-1:0] rd_word_r;
  reg [2:0] irq_pend_r;
  wire tick;
  wire [3:0] gen_par;
  wire [3:0] lane_bad;
  wire [3:0] lane_used;
  wire rd_fifo_ready;
  wire dma_req;
  wire take_req;

  // bus clock is master clock divided by four; transactions step on its fall
  // reset clears the divider, so the first tick falls four master clocks later
  always @(posedge clk_in) begin
    if (rst_in) begin
      div_r <= {`BBX_DIV_W{1'b0}};
      bclk_out <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      bclk_out <= (div_r >= `BBX_DIV_HALF) && (div_r != `BBX_DIV_LAST);
    end
  end
  assign tick = (div_r == `BBX_DIV_LAST);

  // lane usage by width code; reserved code uses no lane
  assign lane_used = (width_r == `BBX_WID_BYTE) ? `BBX_LANE_MASK_BYTE :
                     (width_r == `BBX_WID_WORD) ? `BBX_LANE_MASK_WORD :
                     (width_r == `BBX_WID_DWORD) ? `BBX_LANE_MASK_DWORD : 4'h0;

  // one checker per byte lane; in the write phase it generates our own bits
  genvar g;
  generate
    for (g = 0; g < `BBX_LANES; g = g + 1) begin : g_lane
      bbx_parity_lane u_lane (
        .byte_in(write_r ? wdata_r[8*g+7:8*g] : ad_in[8*g+7:8*g]),
        .par_in(par_in[g]),
        .used_in(lane_used[g] & ~write_r),
        .par_out(gen_par[g]),
        .bad_out(lane_bad[g])
      );
    end
  endgenerate

  // read data buffer; a full buffer holds off new requests
  bbx_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_rd_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(rd_push_r),
    .in_ready_out(rd_fifo_ready),
    .in_data_in(rd_word_r),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );

  assign dma_req = ~dma_bus_request_n_in;
  // new access only while we own the bus, not stopped, and read space exists;
  // a pending dma or master hand-over refuses it, or the strobes would start
  // an access in the very tick that gives the bus away
  assign take_req = (state_r == S_IDLE) & tick & req_valid_in & bus_owned_out
                    & stop_n_in & rd_fifo_ready
                    & ~dma_req & ~other_master_want_in;
  assign req_ready_out = take_req;

  // limitation: one access at a time, taken only from idle on a tick, so
  // back-to-back accesses are five bus ticks apart at best
  // access sequencer: address phase, then data phase on the same lines
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (tick & dma_req & bus_owned_out) begin
          state_nxt = S_OFF;
        end else if (take_req) begin
          state_nxt = S_ADDR;
        end
      end
      S_ADDR: if (tick) state_nxt = S_ALAT;
      S_ALAT: if (tick) state_nxt = S_DATA;
      S_DATA: if (tick & wait_n_in) state_nxt = S_DEND;
      S_DEND: if (tick) state_nxt = S_IDLE;
      S_OFF: if (tick & ~dma_req) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // pin drive and capture per phase
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= S_IDLE;
      ad_out <= {DW{1'b0}};
      ad_oe_out <= 1'b0;
      par_out <= 4'h0;
      par_oe_out <= 1'b0;
      addr_strobe_n_out <= 1'b1;
      data_strobe_n_out <= 1'b1;
      strobe_oe_out <= 1'b0;
      transaction_type_code_out <= `BBX_ST_IDLE;
      byte_sel_out <= 1'b1;
      width_sel_b_out <= 1'b1;
      normal_mode_out <= 1'b1;
      wdata_r <= {DW{1'b0}};
      write_r <= 1'b0;
      width_r <= `BBX_WID_RSVD;
      rd_push_r <= 1'b0;
      rd_word_r <= {DW{1'b0}};
      rd_parity_bad_out <= 1'b0;
      parity_fault_line_oe_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_push_r <= 1'b0;
      strobe_oe_out <= bus_owned_out & (state_nxt != S_OFF);
      normal_mode_out <= ~sys_mode_in;
      if (take_req) begin
        ad_out <= req_addr_in;
        ad_oe_out <= 1'b1;
        addr_strobe_n_out <= 1'b0;
        wdata_r <= req_wdata_in;
        write_r <= req_write_in;
        width_r <= req_width_in;
        {byte_sel_out, width_sel_b_out} <= req_width_in;
        transaction_type_code_out <= ~req_prog_in ? `BBX_ST_DATA :
          (req_first_in ? `BBX_ST_PROG_FIRST : `BBX_ST_PROG_NEXT);
        par_oe_out <= 1'b0;
      end
      if (state_r == S_ADDR && tick) begin
        addr_strobe_n_out <= 1'b1;
        ad_oe_out <= 1'b0;
      end
      if (state_r == S_ALAT && tick) begin
        data_strobe_n_out <= 1'b0;
        if (write_r) begin
          ad_out <= wdata_r;
          ad_oe_out <= 1'b1;
          par_out <= gen_par;
          par_oe_out <= 1'b1;
        end
      end
      // sample read data and check parity as the strobe ends
      if (state_r == S_DATA && tick && wait_n_in) begin
        data_strobe_n_out <= 1'b1;
        ad_oe_out <= 1'b0;
        par_oe_out <= 1'b0;
        if (!write_r) begin
          rd_word_r <= ad_in;
          rd_push_r <= 1'b1;
          rd_parity_bad_out <= |lane_bad;
          parity_fault_line_oe_out <= |lane_bad;
        end
      end
      if (state_r == S_DEND && tick) begin
        parity_fault_line_oe_out <= 1'b0;
        transaction_type_code_out <= `BBX_ST_IDLE;
      end
    end
  end

  // interrupt requests, held until the enable chain reaches this board
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_pend_r <= 3'h0;
      irq_taken_out <= 3'h0;
    end else begin
      irq_taken_out <= irq_pend_r & {lvl3_enable_in, lvl2_enable_in, lvl1_enable_in};
      // a new raise wins over the clear taken in the same cycle
      irq_pend_r <= (irq_pend_r & ~irq_taken_out) | irq_raise_in;
    end
  end
  // bit 0 is level one (highest priority), bit 2 level three
  assign irq_level_oe_out = irq_pend_r;
  assign lvl1_enable_out = lvl1_enable_in & ~irq_pend_r[0];
  assign lvl2_enable_out = lvl2_enable_in & ~irq_pend_r[1];
  assign lvl3_enable_out = lvl3_enable_in & ~irq_pend_r[2];

  // grant chains: a requester keeps the grant, others pass it on
  // the dma grant goes on only once our drivers are off the bus
  assign multiproc_ack_out = multiproc_ack_in & ~multiproc_sync_request_oe_out;
  assign dma_grant_out = dma_grant_in & (state_r == S_OFF);
  assign master_grant_out = master_grant_in & ~master_bus_request_oe_out;

  // ownership, master hand-over, sync request, power fail and stop
  // hand-over waits for an idle tick so an access in flight always ends cleanly
  always @(posedge clk_in) begin
    if (rst_in) begin
      bus_owned_out <= 1'b0;
      master_bus_request_oe_out <= 1'b0;
      master_available_oe_out <= 1'b0;
      multiproc_sync_request_oe_out <= 1'b0;
      mp_sync_granted_out <= 1'b0;
      save_state_out <= 1'b0;
      halted_out <= 1'b0;
    end else begin
      multiproc_sync_request_oe_out <= mp_sync_want_in;
      mp_sync_granted_out <= mp_sync_want_in & multiproc_ack_in;
      save_state_out <= ~power_fail_warning_n_in;
      halted_out <= ~stop_n_in;
      // ask for the bus while not owner and a request is waiting
      master_bus_request_oe_out <= ~bus_owned_out & req_valid_in;
      if (~bus_owned_out & master_bus_request_oe_out & master_grant_in
          & master_available_n_in) begin
        bus_owned_out <= 1'b1;
      end else if (bus_owned_out & other_master_want_in & state_r == S_IDLE & tick) begin
        bus_owned_out <= 1'b0;
      end
      // the available line is driven low while this board holds the bus
      master_available_oe_out <= bus_owned_out;
    end
  end
endmodule // bbx_board
`default_nettype wire

// File: test/bbx_board_props.sv
/*
  concurrent checks on the ports of bbx_board.
  assumes one clock clk_in and a synchronous active high rst_in.
*/
`timescale 1ns/1ps
`default_nettype none
module bbx_board_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic req_prog_in,
  input wire logic req_first_in,
  input wire logic [1:0] req_width_in,
  input wire logic stop_n_in,
  input wire logic wait_n_in,
  input wire logic bclk_out,
  input wire logic addr_strobe_n_out,
  input wire logic data_strobe_n_out,
  input wire logic [4:0] transaction_type_code_out,
  input wire logic byte_sel_out,
  input wire logic width_sel_b_out,
  input wire logic parity_fault_line_oe_out,
  input wire logic multiproc_sync_request_oe_out,
  input wire logic multiproc_ack_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a request counts only where both sides agree at the edge
  wire take = req_valid_in && req_ready_out;
  a_reset_idle: assert property ($past(rst_in) |-> addr_strobe_n_out && data_strobe_n_out
    && transaction_type_code_out == 5'h00) else $error("bus not idle after reset");
  a_phase_excl: assert property (addr_strobe_n_out || data_strobe_n_out)
    else $error("address and data strobes low together");
  a_as_pulse: assert property ($fell(addr_strobe_n_out) |-> !addr_strobe_n_out[*4]
    ##1 addr_strobe_n_out) else $error("address strobe not one bus tick");
  a_bclk_div: assert property ($rose(bclk_out) |-> bclk_out[*2] ##1 !bclk_out[*2]
    ##1 bclk_out) else $error("bus clock not a quarter of master clock");
  a_status_code: assert property (take |=> transaction_type_code_out ==
    (!$past(req_prog_in) ? 5'h08 : $past(req_first_in) ? 5'h0d : 5'h0c))
    else $error("wrong transaction status");
  a_width_lines: assert property (take |=> {byte_sel_out, width_sel_b_out} ==
    $past(req_width_in)) else $error("wrong width select");
  a_stop_refuse: assert property (!stop_n_in |-> !req_ready_out)
    else $error("request taken while stopped");
  a_wait_hold: assert property (!wait_n_in && !data_strobe_n_out |=> !data_strobe_n_out)
    else $error("data phase ended during wait");
  a_fault_pulse: assert property ($rose(parity_fault_line_oe_out) |-> !$past(data_strobe_n_out)
    ##1 parity_fault_line_oe_out[*3] ##1 !parity_fault_line_oe_out)
    else $error("parity fault not one tick after data phase");
  a_chain_block: assert property (multiproc_sync_request_oe_out |-> !multiproc_ack_out)
    else $error("requesting board passed acknowledge on");
  c_dword: cover property (take && req_width_in == 2'h2);
  c_fault: cover property ($rose(parity_fault_line_oe_out));
  c_stretch: cover property (!wait_n_in && !data_strobe_n_out);
endmodule // bbx_board_props
bind bbx_board bbx_board_props u_props (.*);
`default_nettype wire

// File: test/bbx_mem_model.sv
/*
  memory board on the far side: answers reads, takes writes, stretches data phases.
  assumes one driving board; undriven lines float high through the termination.
*/
`timescale 1ns/1ps
`default_nettype none
module bbx_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic present_in,
  input wire logic [3:0] wait_len_in,
  input wire logic [31:0] ad_dut_in,
  input wire logic ad_oe_in,
  input wire logic [3:0] par_dut_in,
  input wire logic par_oe_in,
  input wire logic as_n_in,
  input wire logic ds_n_in,
  output logic [31:0] ad_bus_out,
  output logic [3:0] par_bus_out,
  output logic wait_n_out,
  output logic [31:0] last_addr_out,
  output logic [31:0] last_wdata_out
);
  logic ds_q_r;
  logic [3:0] wcnt_r;
  logic [31:0] rdata;
  logic drive;
  // answer only inside a read data phase; a missing board leaves all ones
  assign rdata = {last_addr_out[15:0], ~last_addr_out[15:0]};
  assign drive = present_in && !ds_n_in && !ad_oe_in;
  assign ad_bus_out = ad_oe_in ? ad_dut_in : drive ? rdata : 32'hffffffff;
  assign par_bus_out = par_oe_in ? par_dut_in : drive ?
    {^rdata[31:24], ^rdata[23:16], ^rdata[15:8], ^rdata[7:0]} : 4'hf;
  assign wait_n_out = (wcnt_r == 4'h0);
  // last value seen while the strobe is low is the one at its rising edge
  always @(posedge clk_in) begin
    ds_q_r <= ds_n_in;
    if (!as_n_in) last_addr_out <= ad_bus_out;
    if (!ds_n_in && ad_oe_in) last_wdata_out <= ad_bus_out;
    if (rst_in) wcnt_r <= 4'h0;
    else if (ds_q_r && !ds_n_in) wcnt_r <= wait_len_in;
    else if (wcnt_r != 4'h0) wcnt_r <= wcnt_r - 4'h1;
  end
endmodule // bbx_mem_model
`default_nettype wire

// File: test/tb_top.sv
/*
  bench for bbx_board with a memory board model on the far side.
  assumes the board must win a master grant before its first access.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'h0, rst_in = 1'h1, req_valid_in = 1'h0, req_write_in = 1'h0;
  logic req_prog_in = 1'h0, req_first_in = 1'h0, sys_mode_in = 1'h0, rd_ready_in = 1'h0;
  logic [1:0] req_width_in = 2'h2;
  logic [31:0] req_addr_in = 32'h0, req_wdata_in = 32'h0, last_addr, last_wdata, k;
  logic [2:0] irq_raise_in = 3'h0;
  logic [3:0] wait_len = 4'h0;
  logic mp_sync_want_in = 1'h0, other_master_want_in = 1'h0, stop_n_in = 1'h1;
  logic power_fail_warning_n_in = 1'h1, lvl1_enable_in = 1'h1, lvl2_enable_in = 1'h1;
  logic lvl3_enable_in = 1'h1, multiproc_ack_in = 1'h0, dma_bus_request_n_in = 1'h1;
  logic dma_grant_in = 1'h0, master_grant_in = 1'h0, master_available_n_in = 1'h1;
  logic present = 1'h1, saw_fault = 1'h0;
  wire req_ready_out, rd_valid_out, rd_parity_bad_out, save_state_out, halted_out;
  wire bus_owned_out, mp_sync_granted_out, ad_oe_out, par_oe_out, addr_strobe_n_out;
  wire data_strobe_n_out, normal_mode_out, parity_fault_line_oe_out, wait_n_in;
  wire lvl1_enable_out, lvl2_enable_out, lvl3_enable_out, multiproc_sync_request_oe_out;
  wire multiproc_ack_out, dma_grant_out, strobe_oe_out;
  wire master_bus_request_oe_out, master_grant_out, master_available_oe_out;
  wire [31:0] rd_data_out, ad_in, ad_out;
  wire [3:0] par_in, par_out;
  wire [2:0] irq_level_oe_out, irq_taken_out;
  int n_mismatch = 0, n_compared = 0, n, i;
  bbx_board u_dut (.*, .bclk_out(), .transaction_type_code_out(), .byte_sel_out(),
    .width_sel_b_out());
  bbx_mem_model u_mem (.clk_in, .rst_in, .present_in(present), .wait_len_in(wait_len),
    .ad_dut_in(ad_out), .ad_oe_in(ad_oe_out), .par_dut_in(par_out), .par_oe_in(par_oe_out),
    .as_n_in(addr_strobe_n_out), .ds_n_in(data_strobe_n_out), .ad_bus_out(ad_in),
    .par_bus_out(par_in), .wait_n_out(wait_n_in), .last_addr_out(last_addr),
    .last_wdata_out(last_wdata));
  always #2.5 clk_in = ~clk_in;
  // a fault pulse is short, so latch that one was seen
  always @(posedge clk_in) if (parity_fault_line_oe_out === 1'h1) saw_fault <= 1'h1;
  task check(input string what, input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // held until the taking edge; a[31] marks program space, a[30] a first fetch
  task access(input [1:0] w, input wr, input [31:0] a, input [31:0] d);
    @(posedge clk_in);
    {req_width_in, req_write_in, req_addr_in, req_wdata_in} <= {w, wr, a, d};
    {req_prog_in, req_first_in, req_valid_in} <= {a[31], a[30], 1'h1};
    for (n = 0; n < 300 && req_ready_out !== 1'h1; n++) @(negedge clk_in);
    if (n == 300) check("request taken", 0, 1);
    @(posedge clk_in);
    req_valid_in <= 1'h0;
  endtask
  task pop(input [31:0] exp, input [31:0] m);
    @(posedge clk_in);
    rd_ready_in <= 1'h1;
    for (n = 0; n < 300 && rd_valid_out !== 1'h1; n++) @(negedge clk_in);
    check("read data", rd_data_out & m, exp & m);
    @(posedge clk_in);
    rd_ready_in <= 1'h0;
  endtask
  task rd(input [1:0] w, input [31:0] a, input bad);
    access(w, 1'h0, a, 32'h0);
    pop(bad ? 32'hffffffff : {a[15:0], ~a[15:0]},
      w == 2'h3 ? 32'hff : w == 2'h1 ? 32'hffff : 32'hffffffff);
    check("parity verdict", rd_parity_bad_out, bad);
    check("latched address", last_addr, a);
  endtask
  task t_start;
    check("idle lines", {addr_strobe_n_out, data_strobe_n_out, ad_oe_out}, 3'h6);
    @(posedge clk_in);
    {master_grant_in, master_available_n_in} <= 2'h3;
    // the board asks for the bus only once it has an access waiting
    access(2'h3, 1'h1, 32'h0, 32'h0);
    @(negedge clk_in);
    check("bus owned", bus_owned_out, 1);
    check("master lines", {master_bus_request_oe_out, master_grant_out}, 2'h1);
    check("available driven", master_available_oe_out, 1);
  endtask
  task t_access;
    rd(2'h3, 32'hc00012a5, 1'h0);
    rd(2'h1, 32'h80005a3c, 1'h0);
    rd(2'h2, 32'h0000f00f, 1'h0);
    check("stray fault", saw_fault, 0);
    access(2'h3, 1'h1, 32'h40, 32'h123456c3);
    repeat (20) @(posedge clk_in);
    check("written byte", last_wdata & 32'hff, 32'hc3);
    wait_len <= 4'hd;
    rd(2'h2, 32'h00000777, 1'h0);
    wait_len <= 4'h0;
    present <= 1'h0;
    rd(2'h2, 32'h00000bad, 1'h1);
    check("fault line", saw_fault, 1);
    present <= 1'h1;
  endtask
  task t_fifo;
    for (i = 0; i < 4; i++) access(2'h2, 1'h0, 32'h100 + i, 32'h0);
    @(posedge clk_in);
    req_valid_in <= 1'h1;
    k = 0;
    repeat (60) @(negedge clk_in) k += req_ready_out;
    @(posedge clk_in);
    req_valid_in <= 1'h0;
    check("taken while full", k, 0);
    for (i = 0; i < 4; i++) pop({16'h100 + i[15:0], ~(16'h100 + i[15:0])}, 32'hffffffff);
  endtask
  task t_chains;
    for (i = 0; i < 2; i++) begin
      @(posedge clk_in);
      {multiproc_ack_in, lvl1_enable_in, lvl2_enable_in, lvl3_enable_in} <= {4{i[0]}};
      @(negedge clk_in);
      check("ack passed", multiproc_ack_out, i);
      check("enables passed", {lvl3_enable_out, lvl2_enable_out, lvl1_enable_out}, {3{i[0]}});
    end
    @(posedge clk_in);
    mp_sync_want_in <= 1'h1;
    for (n = 0; n < 100 && mp_sync_granted_out !== 1'h1; n++) @(negedge clk_in);
    check("sync granted", mp_sync_granted_out, 1);
    check("ack blocked", multiproc_ack_out, 0);
    @(posedge clk_in);
    mp_sync_want_in <= 1'h0;
  endtask
  task t_ctl;
    @(posedge clk_in);
    {stop_n_in, power_fail_warning_n_in, sys_mode_in} <= 3'h1;
    repeat (5) @(negedge clk_in);
    check("halted", halted_out, 1);
    check("state save", save_state_out, 1);
    check("system mode", normal_mode_out, 0);
    @(posedge clk_in);
    {stop_n_in, power_fail_warning_n_in, sys_mode_in} <= 3'h6;
    repeat (5) @(negedge clk_in);
    check("running", {halted_out, save_state_out, normal_mode_out}, 3'h1);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      irq_raise_in <= 3'h1 << i;
      @(posedge clk_in);
      irq_raise_in <= 3'h0;
      repeat (2) @(negedge clk_in);
      check("level pulled", irq_level_oe_out[i], 1);
      check("level taken", irq_taken_out, 3'h1 << i);
    end
  endtask
  task t_dma;
    @(posedge clk_in);
    {dma_bus_request_n_in, dma_grant_in} <= 2'h1;
    for (n = 0; n < 200 && dma_grant_out !== 1'h1; n++) @(negedge clk_in);
    // ownership stays with us; only the drivers come off the bus
    check("dma granted", {dma_grant_out, bus_owned_out, strobe_oe_out}, 3'h6);
    @(posedge clk_in);
    dma_bus_request_n_in <= 1'h1;
    for (n = 0; n < 200 && dma_grant_out !== 1'h0; n++) @(negedge clk_in);
    check("bus taken back", {dma_grant_out, bus_owned_out, strobe_oe_out}, 3'h3);
    rd(2'h2, 32'h00000a0a, 1'h0);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    @(negedge clk_in);
    t_start;
    t_access;
    t_fifo;
    t_chains;
    t_ctl;
    t_dma;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
